//--- hw/st_l1_pkg.sv
// Constants for the line transceiver layer-1 control block
package st_l1_pkg;
  // Clocking of the block
  localparam int PCLK_HZ    = 50_000_000;
  localparam int PCLK_NS    = 20;
  localparam int DCL_HZ     = 1_536_000;
  localparam int DCL_STEP   = 2 * DCL_HZ;
  localparam int DCL_PER_BIT   = 8;
  localparam int BITS_PER_LINE = 48;
  localparam int DCL_PER_FSC   = 192;
  // Transmit frame alignment
  localparam int LINE_BIT_NS = 5208;
  localparam int OSC_NS      = 130;
  localparam int OSC_SHIFT   = 7;
  localparam int TX_SHIFT_NS = 2 * LINE_BIT_NS - OSC_SHIFT * OSC_NS;
  localparam int TX_SHIFT_CYC = TX_SHIFT_NS / PCLK_NS;
  localparam int COMP_NS     = 2 * OSC_NS;
  localparam int COMP_CYC    = (COMP_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int TX_COMP_CYC = TX_SHIFT_CYC - COMP_CYC;
  // Register offsets
  localparam logic [7:0] OFS_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  // Configuration field positions
  localparam int B_PDC   = 0;
  localparam int B_CSP   = 1;
  localparam int B_LDD   = 2;
  localparam int B_TRDIS = 3;
  localparam int B_TXDIS = 4;
  localparam int B_EXTERNAL_LOOP_SELECT  = 5;
  localparam int B_RLOOP = 6;
  localparam int B_FBSEL = 7;
  localparam int B_COEN  = 8;
  localparam int B_ALOOP = 9;
  localparam int B_SMDIS = 10;
  localparam int B_SPU   = 11;
  localparam int CFG_W   = 12;
  localparam logic [CFG_W-1:0] CFG_RESET = 12'h010;
  // Status field positions
  localparam int S_LDIRQ = 0;
  localparam int S_RSY   = 1;
  localparam int S_PD    = 2;
  localparam int S_CLK   = 3;
  localparam int S_LOOP  = 4;
  // Command codes
  localparam logic [3:0] CMD_TIM   = 4'h0;
  localparam logic [3:0] CMD_SSP   = 4'h2;
  localparam logic [3:0] CMD_SCP   = 4'h3;
  localparam logic [3:0] CMD_ARL   = 4'h8;
  localparam logic [3:0] CMD_DEACT = 4'hf;
  localparam logic [3:0] CMD_RESET = 4'hf;
  // Operating modes from the strap pins
  localparam logic [1:0] MODE_TERM  = 2'h0;
  localparam logic [1:0] MODE_TRUNK = 2'h1;
  // Power state
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b01,
    PWR_DOWN   = 2'b10
  } pwr_state_t;
endpackage : st_l1_pkg

//--- hw/st_l1_ctrl.sv
// Layer-1 control around a four-wire line transceiver
//
// Contract
// [RL1] Transmit frame lags receive by two bits minus seven
// [RL2] Compensation bit advances transmit two oscillator periods
// [RL3] Power down keeps clocks unless clock stop set
// [RL4] Stopped clocks: data lines high, clocks low
// [RL5] Line activity restarts clocks when autoclock enabled
// [RL6] Autoclock disabled: line activity raises level interrupt; code: only with clock stop set, else it wakes next cycle
// [RL7] Host wakes via powerup pulse plus timing
// [RL8] Reset: transceiver enabled, transmit buffer disabled
// [RL9] Receiver monitors line with buffer disabled
// [RL10] Transceiver disable stops layer one, clocks input
// [RL11] Analog loop by command or bit
// [RL12] Loop routes transmit to receive, highway echoed
// [RL13] Level detector reports resync during loop
// [RL14] Buffer disable sets loop transparency to line
// [RL15] External loop disables line level detector
// [RL16] Remote loop echoes line, D forwarded, B ones
// [RL17] Single pulse command: one pulse per frame
// [RL18] Continuous pulse command: 48 pulses per frame
// [RL19] Host starts test signals by command write
// [RL20] Terminal mode clocks locked to received frames
// [RL21] Trunk mode outputs line synchronous clock
// [RL22] Divided output gives frame or bit clock
`timescale 1ns/1ps
`default_nettype none
module st_l1_ctrl
  import st_l1_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Straps and line receiver
  input  wire logic [1:0]  mode_strap,
  input  wire logic        line_rx_data,
  input  wire logic        line_rx_frame,
  input  wire logic        line_level,
  // Line transmitter
  output logic             line_tx_pos,
  output logic             line_tx_neg,
  output logic             line_tx_oe_n,
  output logic             tx_frame_start,
  // Serial highway
  input  wire logic        highway_in_data,
  input  wire logic        highway_in_is_d,
  input  wire logic        data_clock_in,
  output logic             downstream_data,
  output logic             upstream_data,
  output logic             data_clock,
  output logic             data_clock_oe_n,
  output logic             frame_sync,
  output logic             frame_sync_oe_n,
  output logic             bit_clock,
  // Auxiliary clocks and events
  output logic             line_synced_clock_out,
  output logic             divided_clock_out_pin,
  output logic             level_detect_irq
);
  import st_l1_pkg::*;

  localparam int NSYNC = 7;
  localparam int A_TX  = TX_SHIFT_CYC;
  localparam int A_TXC = TX_COMP_CYC;

  logic [NSYNC-1:0] sync_raw;
  logic [NSYNC-1:0] sync_q1;
  logic [NSYNC-1:0] sync_q2;
  logic             rx_d;
  logic             rx_frame;
  logic             level;
  logic             hw_d;
  logic             hw_is_d;
  logic             dcl_pin;
  logic [1:0]       mode;
  logic             frame_q;
  logic             frame_edge;
  logic [CFG_W-1:0] config_bits;
  logic [3:0]       command_indication_tx_reg;
  logic             resync_indication;
  logic             spu_armed;
  pwr_state_t       pwr;
  logic             timed_mode;
  logic             term_mode;
  logic             clocks_run;
  logic             clocks_stopped;
  logic             loop_active;
  logic             det_enable;
  logic             wr_en;
  logic             cmd_wr;
  logic [25:0]      nco;
  logic             dcl_tick;
  logic [2:0]       bit_cnt;
  logic [5:0]       line_bit;
  logic [7:0]       fsc_cnt;
  logic             line_bit_tick;
  logic [9:0]       tx_cnt;
  logic             tx_pending;
  logic             pulse_pol;
  logic             tx_mark;
  logic             line_from;
  logic             dcl_src_q;
  logic             dcl_src_rise;
  logic [7:0]       div_cnt;
  logic             div_bcl;
  logic [9:0]       since_edge;

  // Two-stage synchronisers for every pin input
  assign sync_raw = {mode_strap, data_clock_in, highway_in_is_d, highway_in_data, line_level, line_rx_data};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_q1[gi] <= 1'b0;
          sync_q2[gi] <= 1'b0;
        end else begin
          sync_q1[gi] <= sync_raw[gi];
          sync_q2[gi] <= sync_q1[gi];
        end
      end
    end
  endgenerate

  // Frame marker gets its own pair for edge detection
  logic frame_s1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_s1 <= 1'b0;
      rx_frame <= 1'b0;
      frame_q  <= 1'b0;
    end else begin
      frame_s1 <= line_rx_frame;
      rx_frame <= frame_s1;
      frame_q  <= rx_frame;
    end
  end

  // Named views of synchronised inputs
  assign rx_d       = sync_q2[0];
  assign level      = sync_q2[1];
  assign hw_d       = sync_q2[2];
  assign hw_is_d    = sync_q2[3];
  assign dcl_pin    = sync_q2[4];
  assign mode       = sync_q2[6:5];
  assign frame_edge = rx_frame & ~frame_q;

  // Mode and enable decode
  assign term_mode   = (mode == MODE_TERM);
  assign timed_mode  = term_mode || (mode == MODE_TRUNK);
  assign loop_active = (command_indication_tx_reg == CMD_ARL) ||
                       (config_bits[B_ALOOP] && config_bits[B_SMDIS]); // [RL11]
  assign det_enable  = !config_bits[B_TRDIS] && !(loop_active && config_bits[B_EXTERNAL_LOOP_SELECT]); // [RL10] [RL15]
  assign clocks_stopped = (pwr == PWR_DOWN) && config_bits[B_CSP]; // [RL3]
  assign clocks_run  = term_mode && !config_bits[B_TRDIS] && !clocks_stopped; // [RL3] [RL10]

  // APB strobes, zero wait states
  assign wr_en   = psel && penable && pwrite;
  assign cmd_wr  = wr_en && (paddr == OFS_COMMAND);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr != OFS_CONFIG) &&
                   (paddr != OFS_COMMAND) && (paddr != OFS_STATUS);

  // Configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_bits <= CFG_RESET; // [RL8]
    end else if (wr_en && paddr == OFS_CONFIG) begin
      config_bits <= pwdata[CFG_W-1:0];
    end
  end

  // Command register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_indication_tx_reg <= CMD_RESET;
    end else if (cmd_wr) begin
      command_indication_tx_reg <= pwdata[3:0]; // [RL19]
    end
  end

  // Read data sampled in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (paddr == OFS_CONFIG) begin
        prdata <= {20'h00000, config_bits};
      end else if (paddr == OFS_COMMAND) begin
        prdata <= {28'h0000000, command_indication_tx_reg};
      end else if (paddr == OFS_STATUS) begin
        prdata <= {27'h0000000, loop_active, clocks_run, (pwr == PWR_DOWN),
                   resync_indication, level_detect_irq};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Powerup bit must be seen high before it arms a wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spu_armed <= 1'b0;
    end else if (config_bits[B_SPU]) begin
      spu_armed <= 1'b1;
    end else if (cmd_wr && pwdata[3:0] == CMD_TIM) begin
      spu_armed <= 1'b0;
    end
  end

  // Power state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr <= PWR_ACTIVE;
    end else begin
      case (pwr)
        PWR_ACTIVE: begin
          if (cmd_wr && pwdata[3:0] == CMD_DEACT) begin
            pwr <= PWR_DOWN;
          end
        end
        PWR_DOWN: begin
          if (level && det_enable && !config_bits[B_LDD]) begin
            pwr <= PWR_ACTIVE; // [RL5]
          end else if (cmd_wr && pwdata[3:0] == CMD_TIM && spu_armed && !config_bits[B_SPU]) begin
            pwr <= PWR_ACTIVE; // [RL7]
          end else if (!config_bits[B_CSP] && config_bits[B_LDD]) begin
            pwr <= PWR_ACTIVE; // [RL6]
          end
        end
        default: pwr <= PWR_ACTIVE;
      endcase
    end
  end

  // Level interrupt flag, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_detect_irq <= 1'b0;
    end else if (pwr == PWR_DOWN && level && det_enable && config_bits[B_LDD]) begin
      level_detect_irq <= 1'b1; // [RL6]
    end else if (wr_en && paddr == OFS_STATUS && pwdata[S_LDIRQ]) begin
      level_detect_irq <= 1'b0;
    end
  end

  // Resync indication while a loop is closed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resync_indication <= 1'b0;
    end else if (loop_active && det_enable && level) begin
      resync_indication <= 1'b1; // [RL13]
    end else if (wr_en && paddr == OFS_STATUS && pwdata[S_RSY]) begin
      resync_indication <= 1'b0;
    end
  end

  // Data clock generator, phase restarted on received frame in terminal mode only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco      <= 26'h0000000;
      dcl_tick <= 1'b0;
    end else if (frame_edge && term_mode) begin
      nco      <= 26'h0000000; // [RL20]
      dcl_tick <= 1'b0;
    end else if (nco + 26'(DCL_STEP) >= 26'(PCLK_HZ)) begin
      nco      <= nco + 26'(DCL_STEP) - 26'(PCLK_HZ);
      dcl_tick <= 1'b1;
    end else begin
      nco      <= nco + 26'(DCL_STEP);
      dcl_tick <= 1'b0;
    end
  end

  // Highway clocks; stopped clocks sit low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_clock <= 1'b0;
      bit_clock  <= 1'b0;
      frame_sync <= 1'b0;
      fsc_cnt    <= 8'h00;
    end else if (!clocks_run || (frame_edge && term_mode)) begin
      data_clock <= 1'b0; // [RL4] [RL20]
      bit_clock  <= 1'b0;
      frame_sync <= 1'b0;
      fsc_cnt    <= 8'h00;
    end else if (dcl_tick) begin
      data_clock <= !data_clock;
      if (!data_clock) begin
        bit_clock  <= !bit_clock;
        fsc_cnt    <= (fsc_cnt == 8'(DCL_PER_FSC - 1)) ? 8'h00 : fsc_cnt + 8'h01;
        frame_sync <= (fsc_cnt == 8'(DCL_PER_FSC - 1));
      end
    end
  end

  // Line bit and frame position from the data clock
  assign line_bit_tick = dcl_tick && !data_clock && (bit_cnt == 3'(DCL_PER_BIT - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt  <= 3'h0;
      line_bit <= 6'h00;
    end else if (frame_edge && term_mode) begin
      bit_cnt  <= 3'h0;
      line_bit <= 6'h00;
    end else if (dcl_tick && !data_clock) begin
      bit_cnt <= bit_cnt + 3'h1;
      if (line_bit_tick) begin
        line_bit <= (line_bit == 6'(BITS_PER_LINE - 1)) ? 6'h00 : line_bit + 6'h01;
      end
    end
  end

  // Transmit frame launch after the received frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt         <= 10'h000;
      tx_pending     <= 1'b0;
      tx_frame_start <= 1'b0;
    end else if (frame_edge && timed_mode && !config_bits[B_TRDIS]) begin
      tx_cnt         <= config_bits[B_PDC] ? 10'(TX_COMP_CYC - 1) : 10'(TX_SHIFT_CYC - 1); // [RL1] [RL2]
      tx_pending     <= 1'b1;
      tx_frame_start <= 1'b0;
    end else if (tx_pending && tx_cnt == 10'h000) begin
      tx_pending     <= 1'b0;
      tx_frame_start <= 1'b1; // [RL1]
    end else begin
      tx_cnt         <= tx_pending ? tx_cnt - 10'h001 : tx_cnt;
      tx_frame_start <= 1'b0;
    end
  end

  // Transmit marks: test pulses or data
  always_comb begin
    line_from = remote_loop_sel() ? rx_d : hw_d; // [RL16]
    if (command_indication_tx_reg == CMD_SSP) begin
      tx_mark = (line_bit == 6'h00); // [RL17]
    end else if (command_indication_tx_reg == CMD_SCP) begin
      tx_mark = 1'b1; // [RL18]
    end else begin
      tx_mark = !line_from;
    end
  end

  function automatic logic remote_loop_sel();
    remote_loop_sel = config_bits[B_RLOOP];
  endfunction : remote_loop_sel

  // Alternating polarity line driver, one mark per bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_pol   <= 1'b0;
      line_tx_pos <= 1'b0;
      line_tx_neg <= 1'b0;
    end else if (line_bit_tick) begin
      line_tx_pos <= tx_mark && !pulse_pol; // [RL17] [RL18]
      line_tx_neg <= tx_mark && pulse_pol;
      pulse_pol   <= tx_mark ? !pulse_pol : pulse_pol;
    end
  end

  // Line driver enable; receiver path stays live unless the transceiver is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_tx_oe_n <= 1'b1;
    end else begin
      line_tx_oe_n <= config_bits[B_TRDIS] || config_bits[B_TXDIS] || clocks_stopped; // [RL8] [RL9] [RL14]
    end
  end

  // Highway output data with loops and stop state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      downstream_data <= 1'b1;
      upstream_data   <= 1'b1;
    end else if (clocks_stopped || config_bits[B_TRDIS]) begin
      downstream_data <= 1'b1; // [RL4] [RL10]
      upstream_data   <= 1'b1;
    end else begin
      if (loop_active) begin
        downstream_data <= term_mode ? hw_d : 1'b1; // [RL12]
        upstream_data   <= term_mode ? 1'b1 : hw_d;
      end else if (config_bits[B_RLOOP]) begin
        downstream_data <= term_mode ? (hw_is_d ? rx_d : 1'b1) : 1'b1; // [RL16]
        upstream_data   <= term_mode ? 1'b1 : (hw_is_d ? rx_d : 1'b1);
      end else begin
        downstream_data <= term_mode ? rx_d : 1'b1;
        upstream_data   <= term_mode ? 1'b1 : rx_d;
      end
    end
  end

  // Clock pin directions and trunk clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_clock_oe_n       <= 1'b0;
      frame_sync_oe_n       <= 1'b0;
      line_synced_clock_out <= 1'b0;
    end else begin
      data_clock_oe_n       <= !term_mode || config_bits[B_TRDIS]; // [RL10] [RL21]
      frame_sync_oe_n       <= !term_mode || config_bits[B_TRDIS];
      line_synced_clock_out <= (mode == MODE_TRUNK) && !config_bits[B_TRDIS] &&
                               (dcl_tick ? !line_synced_clock_out : line_synced_clock_out); // [RL21]
    end
  end

  // Divided clock output from whichever data clock is in use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcl_src_q <= 1'b0;
    end else begin
      dcl_src_q <= data_clock_oe_n ? dcl_pin : data_clock;
    end
  end
  assign dcl_src_rise = (data_clock_oe_n ? dcl_pin : data_clock) && !dcl_src_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt               <= 8'h00;
      div_bcl               <= 1'b0;
      divided_clock_out_pin <= 1'b0;
    end else if (!config_bits[B_COEN]) begin
      div_cnt               <= 8'h00;
      div_bcl               <= 1'b0;
      divided_clock_out_pin <= 1'b0;
    end else if (dcl_src_rise) begin
      div_bcl <= !div_bcl;
      div_cnt <= (div_cnt == 8'(DCL_PER_FSC - 1)) ? 8'h00 : div_cnt + 8'h01;
      divided_clock_out_pin <= config_bits[B_FBSEL] ? !div_bcl :
                               (div_cnt == 8'(DCL_PER_FSC - 1)); // [RL22]
    end
  end

  // Cycles since the last received frame edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_edge <= 10'h000;
    end else if (frame_edge) begin
      since_edge <= 10'h001;
    end else if (since_edge != 10'h3ff) begin
      since_edge <= since_edge + 10'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_down_with_level;
    pwr == PWR_DOWN && level && det_enable;
  endsequence

  sequence s_woken;
    pwr == PWR_ACTIVE;
  endsequence

  property p_launch_plain;
    tx_frame_start && !$past(config_bits[B_PDC], 2) |-> since_edge == 10'(A_TX + 1);
  endproperty
  a_launch_plain: assert property (p_launch_plain) else $error("transmit launch off"); // [RL1]

  property p_launch_comp;
    frame_edge && timed_mode && config_bits[B_PDC] && !config_bits[B_TRDIS] ##1
      (!frame_edge && $stable(config_bits)) [*8] |-> ##[1:480] tx_frame_start && since_edge == 10'(A_TXC + 1);
  endproperty
  a_launch_comp: assert property (p_launch_comp) else $error("compensated launch off"); // [RL2]

  property p_pd_clocks;
    pwr == PWR_DOWN && !config_bits[B_CSP] && term_mode && !config_bits[B_TRDIS] |-> clocks_run;
  endproperty
  a_pd_clocks: assert property (p_pd_clocks) else $error("clocks lost in power down"); // [RL3]

  property p_stopped_pins;
    clocks_stopped ##1 clocks_stopped |-> downstream_data && upstream_data && !data_clock && !bit_clock;
  endproperty
  a_stopped_pins: assert property (p_stopped_pins) else $error("stopped pin levels wrong"); // [RL4]

  property p_autowake;
    s_down_with_level ##0 !config_bits[B_LDD] |=> s_woken;
  endproperty
  a_autowake: assert property (p_autowake) else $error("no automatic wake"); // [RL5]

  property p_ld_irq;
    s_down_with_level ##0 config_bits[B_LDD] |=> level_detect_irq ##0 pwr == PWR_DOWN;
  endproperty
  a_ld_irq: assert property (p_ld_irq) else $error("level interrupt missing"); // [RL6]

  property p_buf_off;
    config_bits[B_TXDIS] |=> line_tx_oe_n;
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffer driven while disabled"); // [RL14]

  property p_tr_off;
    config_bits[B_TRDIS] ##1 config_bits[B_TRDIS] |-> data_clock_oe_n && frame_sync_oe_n && !clocks_run;
  endproperty
  a_tr_off: assert property (p_tr_off) else $error("clock pins not inputs"); // [RL10]

  property p_remote_b;
    config_bits[B_RLOOP] && !loop_active && term_mode && !hw_is_d && !clocks_stopped &&
      !config_bits[B_TRDIS] |=> downstream_data;
  endproperty
  a_remote_b: assert property (p_remote_b) else $error("remote loop B not ones"); // [RL16]

endmodule : st_l1_ctrl
`default_nettype wire

//--- test/line_partner.sv
// Partner model of the remote line transceiver: frame markers, bits, level
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  // Clock
  input  wire logic pclk,
  // Bench control
  input  wire logic active,
  // Line toward the receiver
  output logic      line_rx_data,
  output logic      line_rx_frame,
  output logic      line_level
);
  int cnt = 0;
  initial {line_rx_data, line_rx_frame, line_level} = 3'b100;
  // Frame marker every 12500 cycles while active; idle line rests high
  always @(posedge pclk) begin
    cnt           <= (cnt == 12499 || !active) ? 0 : cnt + 1;
    line_rx_frame <= active && cnt < 10;
    line_rx_data  <= active ? ~line_rx_data : 1'b1;
    line_level    <= active;
  end
endmodule : line_partner
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the layer-1 control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import st_l1_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        active = 1'b0, hw_data = 1'b1, en_chk = 1'b0, prev_frame = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, line_rx_data, line_rx_frame, line_level, tx_frame_start;
  logic        downstream_data, upstream_data, data_clock, bit_clock, level_detect_irq;
  logic        line_tx_pos, line_tx_neg, en_loop = 1'b0;
  logic [1:0]  prev_pn = 2'b00;
  logic [2:0]  hist = 3'b000;
  int          n_pos = 0, n_neg = 0, p0, q0;
  int          mismatches = 0, n_checks = 0, cyc = 0, dly = 478, seed = 46;
  int          due[$];

  // Clock
  always #10 pclk = ~pclk;

  st_l1_ctrl dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mode_strap(MODE_TERM), .line_rx_data, .line_rx_frame, .line_level,
    .line_tx_pos, .line_tx_neg, .line_tx_oe_n(), .tx_frame_start,
    .highway_in_data(hw_data), .highway_in_is_d(cyc[3]), .data_clock_in(1'b0),
    .downstream_data, .upstream_data, .data_clock, .data_clock_oe_n(), .frame_sync(),
    .frame_sync_oe_n(), .bit_clock, .line_synced_clock_out(), .divided_clock_out_pin(),
    .level_detect_irq
  );

  line_partner far_end (.pclk, .active, .line_rx_data, .line_rx_frame, .line_level);

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Verdict and end of run
  task automatic test_done;
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  // Launch-time model: each received frame schedules one transmit launch
  always @(posedge pclk) begin
    cyc        <= cyc + 1;
    prev_frame <= line_rx_frame;
    hw_data    <= 1'($random(seed));
    prev_pn    <= {line_tx_pos, line_tx_neg};
    hist       <= {hist[1:0], hw_data};
    if (line_tx_pos && !prev_pn[1]) n_pos <= n_pos + 1;
    if (line_tx_neg && !prev_pn[0]) n_neg <= n_neg + 1;
    if (en_loop) chk("loop echo", hist[2], downstream_data);
    if (en_chk && line_rx_frame && !prev_frame) due.push_back(cyc + dly);
    if (en_chk && tx_frame_start === 1'b1)
      chk("tx_frame_start", (due.size() > 0) ? due.pop_front() : -1, cyc);
  end

  // Watchdog
  initial begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFS_CONFIG, 0);
    chk("config reset", {20'h0, CFG_RESET}, rd);
    apb(0, OFS_COMMAND, 0);
    chk("command reset", 32'hf, rd & 32'hf);
    apb(0, 8'h0c, 0);
    chk("unmapped error", 1, err);
    chk("unmapped read", 0, rd);
    en_chk <= 1'b1;
    active <= 1'b1;
    repeat (14000) @(posedge pclk);
    apb(1, OFS_CONFIG, 32'h011);
    dly = 465;
    repeat (12000) @(posedge pclk);
    en_chk <= 1'b0;
    active <= 1'b0;
    chk("pending launches", 0, due.size());
    // Power down with clocks kept
    apb(1, OFS_CONFIG, 32'h010);
    apb(1, OFS_COMMAND, {28'h0, CMD_DEACT});
    repeat (20) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    chk("status clocks kept", 32'h0c, rd & 32'h1c);
    // Power down with clocks stopped
    apb(1, OFS_CONFIG, 32'h012);
    apb(1, OFS_COMMAND, {28'h0, CMD_DEACT});
    repeat (20) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    chk("status stopped", 32'h04, rd & 32'h1c);
    chk("stopped lines", 4'b1100, {downstream_data, upstream_data, data_clock, bit_clock});
    active <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    chk("status woken", 32'h08, rd & 32'h1c);
    active <= 1'b0;
    // Autoclock disabled: level raises interrupt only
    apb(1, OFS_CONFIG, 32'h016);
    apb(1, OFS_COMMAND, {28'h0, CMD_DEACT});
    repeat (20) @(posedge pclk);
    active <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    chk("status irq", 32'h05, rd & 32'h1d);
    chk("irq pin", 1, level_detect_irq);
    active <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1, OFS_STATUS, 32'h3);
    apb(0, OFS_STATUS, 0);
    chk("irq cleared", 0, rd & 32'h1);
    // Host wake: powerup pulse then timing request
    apb(1, OFS_CONFIG, 32'h816);
    apb(1, OFS_CONFIG, 32'h016);
    apb(1, OFS_COMMAND, {28'h0, CMD_TIM});
    repeat (20) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    chk("status host wake", 32'h08, rd & 32'h0c);
    // Test pulses counted over whole line frames
    apb(1, OFS_CONFIG, 32'h010);
    active <= 1'b1;
    apb(1, OFS_COMMAND, {28'h0, CMD_SSP});
    repeat (1000) @(posedge pclk);
    p0 = n_pos;
    q0 = n_neg;
    repeat (25000) @(posedge pclk);
    chk("single pulses positive", 1, n_pos - p0);
    chk("single pulses negative", 1, n_neg - q0);
    apb(1, OFS_COMMAND, {28'h0, CMD_SCP});
    repeat (500) @(posedge pclk);
    p0 = n_pos;
    q0 = n_neg;
    repeat (12500) @(posedge pclk);
    chk("continuous pulses positive", 24, n_pos - p0);
    chk("continuous pulses negative", 24, n_neg - q0);
    // Analog loop: highway echoed, line level reported as resync
    apb(1, OFS_COMMAND, {28'h0, CMD_ARL});
    en_loop <= 1'b1;
    repeat (50) @(posedge pclk);
    en_loop <= 1'b0;
    apb(0, OFS_STATUS, 0);
    chk("status analog loop", 32'h1a, rd & 32'h1e);
    // External loop: detector off, resync stays clear
    apb(1, OFS_CONFIG, 32'h030);
    apb(1, OFS_STATUS, 32'h2);
    apb(0, OFS_STATUS, 0);
    chk("external loop resync", 0, rd & 32'h2);
    // Remote loop with B slots forced to ones
    apb(1, OFS_COMMAND, {28'h0, CMD_TIM});
    apb(1, OFS_CONFIG, 32'h050);
    repeat (50) @(posedge pclk);
    test_done();
  end
endmodule : tb
`default_nettype wire
